// ---- dv/mrf_host.sv ----
// mrf_host: host on the serial output; collects framed characters.
// assumes 8 data bits, no parity, one stop, DIV clocks per bit.
`timescale 1ns/1ps
module mrf_host #(
  parameter int DIV = 8 // same speed as the modem
) (
  input wire logic sys_clk,
  input wire logic ser_txd
);
  logic [7:0] q[$];
  logic [7:0] b;
  initial begin
    forever begin
      @(negedge ser_txd);
      repeat (DIV / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin // lsb first
        repeat (DIV) @(posedge sys_clk);
        b[i] = ser_txd;
      end
      repeat (DIV) @(posedge sys_clk);
      q.push_back(b);
    end
  end
endmodule

// ---- dv/mrf_top_monitor.sv ----
// mrf_top_monitor: bus, radio and serial checks on the mrf_top ports.
// assumes the shortened timing that the bench sets.
`timescale 1ns/1ps
module mrf_chk
  import mrf_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        ser_txd,
  input wire logic        rf_busy,
  input wire logic        rf_ack_req,
  input mrf_pkg::mrf_rf_t rf_tx,
  input mrf_pkg::mrf_rf_t rf_rx
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_bc_end; rf_rx.valid && rf_rx.last && rf_rx.dst == MRF_BCAST; endsequence
  a_ack_follows: assert property (s_req |=> wb_ack_o) else $error("no ack");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  a_txd_idle: assert property ($rose(rst_b) |-> ser_txd) else $error("line not idle");
  // an ack would land about 40 cycles after the last beat
  a_bc_no_ack: assert property (s_bc_end |-> ##36 !rf_ack_req [*8]) else $error("bcast ack");
  a_unit_gap: assert property (rf_tx.valid && rf_tx.last |=> !rf_tx.valid) else $error("gap");
  a_cs_busy: assert property ($rose(rf_busy) |-> ##2 !(rf_tx.valid && rf_tx.first) [*5])
    else $error("sent while busy");
  a_beat_first: assert property ($rose(rf_tx.valid) |-> rf_tx.first) else $error("no first");
endmodule
bind mrf_top mrf_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ser_txd(ser_txd), .rf_busy(rf_busy),
  .rf_ack_req(rf_ack_req), .rf_tx(rf_tx), .rf_rx(rf_rx));

// ---- dv/tb_top.sv ----
// tb_top: self-checking bench for mrf_top.
// assumes shortened timing and a serial divider of 8.
`timescale 1ns/1ps
module tb_top;
  import mrf_pkg::*;
  logic        sys_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ser_txd, rf_busy;
  logic        rf_ack_req, rf_ack_vld;
  logic [7:0]  wb_adr_i, rf_ack_dst, rf_ack_src, s;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  mrf_rf_t     rf_tx, rf_rx;
  logic [7:0]  m[32];
  logic [7:0]  e[$];
  int          n_errors, n_checks, nb, nu, na, cyc_n, seed;
  localparam int T_DEC = 20, T_BLD = 10, T_CS = 5, T_AIR = 40;
  localparam int T_RXP = 30, T_AKG = 10, T_AKP = 10, T_AKW = 100;
  mrf_top #(.DECODE_CYC(T_DEC), .BUILD_CYC(T_BLD), .CS_CYC(T_CS), .AIR_CYC(T_AIR),
    .RXPROC_CYC(T_RXP), .ACKGEN_CYC(T_AKG), .ACKPROC_CYC(T_AKP), .ACKWAIT_CYC(T_AKW))
    u_dut (.sys_clk, .rst_b,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .ser_txd, .rf_tx, .rf_rx, .rf_busy, .rf_ack_vld, .rf_ack_src, .rf_ack_req,
    .rf_ack_dst);
  mrf_host u_host (.sys_clk, .ser_txd);
  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic final_report();
    $display("Checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge sys_clk); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  // b[0] binary sender, b[1] headerless sender
  task automatic rx(input logic [7:0] d, input logic [7:0] q, input int n, input logic [1:0] b);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      rf_rx <= '{1'h1, i == 0, i == n - 1, 1'h1, 1'h1, b[0], b[1], 3'h0, s, d, q, m[i]};
    end
    @(posedge sys_clk);
    rf_rx <= '0;
  endtask
  // expected serial text: header letters, three digits of the sender, three of the length for binary, message, crlf
  function automatic void exp(input logic [7:0] t, input int n, input logic [7:0] ln);
    e = '{MRF_CH_R, t, t == MRF_CH_X ? MRF_CH_T : MRF_CH_N};
    e = {e, 8'h30 + s / 100, 8'h30 + s / 10 % 10, 8'h30 + s % 10};
    if (t == MRF_CH_B) e = {e, MRF_CH_0, MRF_CH_0, 8'h30 + ln};
    for (int i = 0; i < n; i++) e.push_back(m[i]);
    e = {e, MRF_CH_CR, MRF_CH_LF};
  endfunction
  task automatic cmpq();
    while (u_host.q.size() < e.size()) @(posedge sys_clk);
    foreach (e[i]) chk(u_host.q[i], e[i]);
    u_host.q = {};
  endtask
  always @(posedge sys_clk) begin
    cyc_n++;
    if (rf_tx.valid === 1'h1) nb++;
    if (rf_tx.valid === 1'h1 && rf_tx.first === 1'h1) nu++;
    if (rf_ack_req === 1'h1) na++;
    if (cyc_n == 40000) begin
      n_errors++;
      $display("Error at %0t: timeout", $time);
      final_report();
    end
  end
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, rf_busy, rf_ack_vld, rst_b} = '0;
    {wb_adr_i, wb_dat_i, rf_rx, rf_ack_src} = '0;
    wb_sel_i = 4'hf;
    seed = 32'h8b96;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'h1;
    wb(0, MRF_REG_RETRY, 0);
    chk(rd, 32'h0000_0003);
    wb(0, MRF_REG_LINE, 0);
    chk(rd, 32'h0000_087a);
    wb(0, 8'hfc, 0);
    chk(rd, 0);
    wb(1, MRF_REG_LINE, 32'h0000_0008);
    wb(1, MRF_REG_MODE, 32'h0000_000e);
    foreach (m[i]) m[i] = $random(seed);
    s = $random(seed) & 8'h7f;
    exp(MRF_CH_X, 5, 0);
    rx(MRF_BCAST, 8'h01, 5, 0);
    cmpq();
    rx(MRF_BCAST, 8'h01, 5, 0);
    repeat (1500) @(posedge sys_clk);
    chk(u_host.q.size(), 0);
    chk(na, 0);
    exp(MRF_CH_B, 7, 7);
    rx(8'h00, 8'h02, 7, 1);
    cmpq();
    chk(na, 1);
    chk(rf_ack_dst, s);
    wb(1, MRF_REG_RETRY, 32'h0000_0002);
    for (int i = 0; i < 30; i++) wb(1, MRF_REG_TXDATA, {24'h0, m[i]});
    nb = 0;
    nu = 0;
    wb(1, MRF_REG_SEND, 32'h8000_ff1e);
    // busy spans the quiet interval, so the first unit must slip
    repeat (28) @(posedge sys_clk);
    rf_busy <= 1'h1;
    repeat (6) @(posedge sys_clk);
    rf_busy <= 1'h0;
    repeat (3) @(posedge sys_clk);
    chk(nu, 0);
    e = '{MRF_CH_P, MRF_CH_1, MRF_CH_CR, MRF_CH_LF, MRF_CH_P, MRF_CH_0, MRF_CH_CR, MRF_CH_LF};
    while (u_host.q.size() < 5) @(posedge sys_clk);
    chk(nu, 6);
    chk(nb, 90);
    cmpq();
    // unicast, same responses: the first copy times out, the retry is acknowledged
    for (int i = 0; i < 3; i++) wb(1, MRF_REG_TXDATA, {24'h0, m[i]});
    nb = 0;
    nu = 0;
    wb(1, MRF_REG_SEND, 32'h8000_0503);
    while (nu < 2) @(posedge sys_clk);
    repeat (60) @(posedge sys_clk);
    rf_ack_vld <= 1'h1;
    rf_ack_src <= 8'h05;
    @(posedge sys_clk);
    rf_ack_vld <= 1'h0;
    cmpq();
    chk(nb, 6);
    exp(MRF_CH_B, 5, 5);
    rx(8'h00, 8'h04, 5, 2'h2);
    cmpq();
    chk(na, 2);
    wb(1, MRF_REG_MODE, 32'h0000_0001);
    wb(1, MRF_REG_RXOPT, 32'h0000_0010);
    e = '{m[0], m[1], m[2], m[3], MRF_CH_CR, MRF_CH_LF};
    rx(8'h00, 8'h03, 4, 0);
    cmpq();
    wb(1, MRF_REG_RXOPT, 32'h0000_0000);
    e = '{m[0], m[1], m[2]};
    rx(8'h00, 8'h05, 3, 0);
    cmpq();
    final_report();
  end
endmodule

// ---- hdl/mrf_pkg.sv ----
// mrf_pkg: constants, register map and carrier types for the modem packet framer.
// assumes a single 250 MHz clock; all durations are converted to cycles here.
package mrf_pkg;
  localparam real MRF_CLK_NS        = 4.0;
  localparam real MRF_T_DECODE_MS   = 1.5;
  localparam real MRF_T_BUILD_MS    = 1.0;
  localparam real MRF_T_CS_MS       = 0.1;
  localparam real MRF_T_AIR_MS      = 0.45;
  localparam real MRF_T_RXPROC_MS   = 2.4;
  localparam real MRF_T_ACKGEN_MS   = 1.0;
  localparam real MRF_T_ACKPROC_MS  = 1.0;
  localparam real MRF_NS_PER_MS     = 1.0e6;

  function automatic int unsigned ms2cyc(input real ms);
    return $rtoi($ceil(ms * MRF_NS_PER_MS / MRF_CLK_NS));
  endfunction

  localparam int unsigned MRF_DECODE_CYC  = ms2cyc(MRF_T_DECODE_MS);
  localparam int unsigned MRF_BUILD_CYC   = ms2cyc(MRF_T_BUILD_MS);
  localparam int unsigned MRF_CS_CYC      = ms2cyc(MRF_T_CS_MS);
  localparam int unsigned MRF_AIR_CYC     = ms2cyc(MRF_T_AIR_MS);
  localparam int unsigned MRF_RXPROC_CYC  = ms2cyc(MRF_T_RXPROC_MS);
  localparam int unsigned MRF_ACKGEN_CYC  = ms2cyc(MRF_T_ACKGEN_MS);
  localparam int unsigned MRF_ACKPROC_CYC = ms2cyc(MRF_T_ACKPROC_MS);
  // ack wait covers data air time, far-end processing, ack build and ack air time
  localparam int unsigned MRF_ACKWAIT_CYC = ms2cyc(MRF_T_AIR_MS + MRF_T_RXPROC_MS
                                                 + MRF_T_ACKGEN_MS + MRF_T_AIR_MS);
  localparam int          MRF_TW          = 21;

  localparam int          MRF_MSG_N   = 130;
  localparam logic [7:0]  MRF_MSG_MAX = 8'h82;
  localparam logic [7:0]  MRF_UNIT    = 8'h1a;
  localparam logic [7:0]  MRF_BCAST   = 8'hff;
  localparam logic [7:0]  MRF_HDR_TXT = 8'h06;
  localparam logic [7:0]  MRF_HDR_BIN = 8'h09;
  localparam logic [7:0]  MRF_CRLF_N  = 8'h02;
  localparam logic [7:0]  MRF_RESP_N  = 8'h04;

  localparam logic [7:0]  MRF_CH_CR   = 8'h0d;
  localparam logic [7:0]  MRF_CH_LF   = 8'h0a;
  localparam logic [7:0]  MRF_CH_R    = 8'h52;
  localparam logic [7:0]  MRF_CH_X    = 8'h58;
  localparam logic [7:0]  MRF_CH_T    = 8'h54;
  localparam logic [7:0]  MRF_CH_B    = 8'h42;
  localparam logic [7:0]  MRF_CH_N    = 8'h4e;
  localparam logic [7:0]  MRF_CH_P    = 8'h50;
  localparam logic [7:0]  MRF_CH_0    = 8'h30;
  localparam logic [7:0]  MRF_CH_1    = 8'h31;

  localparam logic [7:0]  MRF_REG_MODE   = 8'h00;
  localparam logic [7:0]  MRF_REG_RETRY  = 8'h04;
  localparam logic [7:0]  MRF_REG_RXOPT  = 8'h08;
  localparam logic [7:0]  MRF_REG_LINE   = 8'h0c;
  localparam logic [7:0]  MRF_REG_ADDR   = 8'h10;
  localparam logic [7:0]  MRF_REG_SEND   = 8'h14;
  localparam logic [7:0]  MRF_REG_STATUS = 8'h18;
  localparam logic [7:0]  MRF_REG_TXDATA = 8'h1c;

  localparam int MRF_MODE_HDRLESS = 0;
  localparam int MRF_MODE_RESP    = 1;
  localparam int MRF_MODE_ACCEPT  = 2;
  localparam int MRF_MODE_ADRCHK  = 3;
  localparam int MRF_RXOPT_CRLF   = 4;
  localparam int MRF_SEND_BIN     = 16;
  localparam int MRF_SEND_GO      = 31;

  localparam logic [15:0] MRF_DIV_RST   = 16'h087a;
  localparam logic [3:0]  MRF_RETRY_RST = 4'h3;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001, S_DECODE = 9'h002, S_BUILD = 9'h004, S_CS = 9'h008,
    S_AIR = 9'h010, S_AWAIT = 9'h020, S_ACKPROC = 9'h040, S_DONE = 9'h080,
    S_SPARE = 9'h100
  } mrf_snd_t;

  typedef enum logic [3:0] {
    R_IDLE = 4'h1, R_PROC = 4'h2, R_ACKG = 4'h4, R_OUT = 4'h8
  } mrf_rcv_t;

  typedef struct packed {
    logic [15:0] div;
    logic        stop2;
    logic        par_odd;
    logic        par_en;
    logic        d7;
  } mrf_line_t;

  // one beat of a radio unit; header fields are meaningful on the first beat
  typedef struct packed {
    logic       valid;
    logic       first;
    logic       last;
    logic       dv;
    logic       fin;
    logic       bin;
    logic       hl;
    logic [2:0] uix;
    logic [7:0] src;
    logic [7:0] dst;
    logic [7:0] seq;
    logic [7:0] data;
  } mrf_rf_t;
endpackage

// ---- hdl/mrf_top.sv ----
// mrf_top: modem packet framer - sender sequencing, receiver serial formatting,
// broadcast handling, wishbone classic register slave.
// assumes a radio front end that streams unit beats and reports channel busy.
`timescale 1ns/1ps

module mrf_top #(
  parameter int unsigned DECODE_CYC  = mrf_pkg::MRF_DECODE_CYC,
  parameter int unsigned BUILD_CYC   = mrf_pkg::MRF_BUILD_CYC,
  parameter int unsigned CS_CYC      = mrf_pkg::MRF_CS_CYC,
  parameter int unsigned AIR_CYC     = mrf_pkg::MRF_AIR_CYC,
  parameter int unsigned RXPROC_CYC  = mrf_pkg::MRF_RXPROC_CYC,
  parameter int unsigned ACKGEN_CYC  = mrf_pkg::MRF_ACKGEN_CYC,
  parameter int unsigned ACKPROC_CYC = mrf_pkg::MRF_ACKPROC_CYC,
  parameter int unsigned ACKWAIT_CYC = mrf_pkg::MRF_ACKWAIT_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             ser_txd,
  output mrf_pkg::mrf_rf_t rf_tx,
  input  mrf_pkg::mrf_rf_t rf_rx,
  input  wire logic        rf_busy,
  input  wire logic        rf_ack_vld,
  input  wire logic [7:0]  rf_ack_src,
  output logic             rf_ack_req,
  output logic      [7:0]  rf_ack_dst
);
  import mrf_pkg::*;

  typedef struct packed {
    mrf_snd_t                      s;
    mrf_rcv_t                      r;
    logic [MRF_TW-1:0]             st;
    logic [MRF_TW-1:0]             rt;
    logic [3:0]                    mode;
    logic [3:0]                    retry;
    logic [7:0]                    rxopt;
    mrf_line_t                     line;
    logic [7:0]                    own;
    logic [7:0]                    hdst;
    logic [MRF_MSG_N-1:0][7:0]     txb;
    logic [7:0]                    txlen;
    logic [7:0]                    wptr;
    logic [7:0]                    dst;
    logic [7:0]                    seq;
    logic [7:0]                    uoff;
    logic [7:0]                    bidx;
    logic [2:0]                    uix;
    logic                          bin;
    logic                          hl;
    logic [3:0]                    tries;
    logic [MRF_MSG_N-1:0][7:0]     rxb;
    logic [7:0]                    rxlen;
    mrf_rf_t                       rh;
    logic [7:0]                    usrc;
    logic [2:0]                    unext;
    logic                          inu;
    logic                          keep;
    logic                          ackn;
    logic                          ufin;
    logic                          lval;
    logic [7:0]                    lsrc;
    logic [7:0]                    lseq;
    logic                          ob;
    logic                          orx;
    logic                          ohl;
    logic [7:0]                    opos;
    logic [7:0]                    olen;
    logic                          rq;
    logic                          rcode;
    logic                          ack;
    logic [31:0]                   dat;
    mrf_rf_t                       tx;
    logic                          aok;
    logic [7:0]                    adst;
    logic                          err;
    logic                          fail;
    logic                          done;
  } mrf_state_t;

  mrf_state_t q, n;
  logic        u_ready;
  logic [7:0]  ch;

  function automatic logic [7:0] dec_digit(input logic [7:0] v, input logic [1:0] pos);
    logic [7:0] d;
    d = 8'h00;
    case (pos)
      2'h0:    d = v / 8'h64;
      2'h1:    d = (v / 8'h0a) % 8'h0a;
      default: d = v % 8'h0a;
    endcase
    return d + MRF_CH_0;
  endfunction

  always_comb begin
    logic [31:0]       rd;
    logic [31:0]       m;
    logic [MRF_TW-1:0] lim;
    logic [MRF_TW-1:0] rlim;
    logic [7:0]        rem;
    logic [7:0]        ulen;
    logic [7:0]        hlen;
    logic [7:0]        p;
    logic [7:0]        base;
    logic              tdone;
    logic              rdone;
    logic              lastu;
    logic              nxt;
    logic              obin;
    logic              kp;
    logic              acc;
    rd    = '0;
    m     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    lim   = '0;
    rlim  = '0;
    rem   = q.txlen - q.uoff;
    ulen  = (rem > MRF_UNIT) ? MRF_UNIT : rem;
    lastu = (q.uoff + ulen) >= q.txlen;
    nxt   = 1'b0;
    obin  = q.rh.bin || q.rh.hl;
    hlen  = q.ohl ? 8'h00 : (obin ? MRF_HDR_BIN : MRF_HDR_TXT);
    p     = q.opos;
    base  = '0;
    kp    = q.keep;
    acc   = 1'b0;
    ch    = '0;
    n       = q;
    n.ack   = 1'b0;
    n.aok   = 1'b0;
    n.tx    = '0;
    n.st    = q.st + MRF_TW'(1);
    n.rt    = q.rt + MRF_TW'(1);

    // register read view
    case (wb_adr_i)
      MRF_REG_MODE:   rd = {28'h0, q.mode};
      MRF_REG_RETRY:  rd = {28'h0, q.retry};
      MRF_REG_RXOPT:  rd = {24'h0, q.rxopt};
      MRF_REG_LINE:   rd = {12'h0, q.line.stop2, q.line.par_odd, q.line.par_en,
                            q.line.d7, q.line.div};
      MRF_REG_ADDR:   rd = {16'h0, q.hdst, q.own};
      MRF_REG_SEND:   rd = {8'h0, 7'h0, q.bin, q.dst, q.txlen};
      MRF_REG_STATUS: rd = {q.wptr, q.unext, q.r, q.s, 4'h0, q.ob, q.fail, q.err, q.done};
      default:        rd = '0;
    endcase

    // wishbone classic slave: answer one cycle after the strobe
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      n.ack = 1'b1;
      n.dat = wb_we_i ? 32'h0000_0000 : rd;
      if (wb_we_i) begin
        case (wb_adr_i)
          MRF_REG_MODE:  n.mode = (q.mode & ~m[3:0]) | (wb_dat_i[3:0] & m[3:0]);
          MRF_REG_RETRY: if (wb_sel_i[0]) n.retry = wb_dat_i[3:0];
          MRF_REG_RXOPT: if (wb_sel_i[0]) n.rxopt = wb_dat_i[7:0];
          MRF_REG_LINE: begin
            n.line.div = (q.line.div & ~m[15:0]) | (wb_dat_i[15:0] & m[15:0]);
            if (wb_sel_i[2]) {n.line.stop2, n.line.par_odd, n.line.par_en, n.line.d7}
                               = wb_dat_i[19:16];
          end
          MRF_REG_ADDR: begin
            if (wb_sel_i[0]) n.own = wb_dat_i[7:0];
            if (wb_sel_i[1]) n.hdst = wb_dat_i[15:8];
          end
          MRF_REG_TXDATA: begin
            // bytes beyond the buffer are dropped; the count check below rejects them
            if (wb_sel_i[0] && q.s == S_IDLE && q.wptr < MRF_MSG_MAX) begin
              n.txb[q.wptr] = wb_dat_i[7:0];
              n.wptr        = q.wptr + 8'h01;
            end
          end
          MRF_REG_SEND: begin
            if (wb_sel_i == 4'hf && wb_dat_i[MRF_SEND_GO] && q.s == S_IDLE) begin
              n.s     = S_DECODE;
              n.st    = '0;
              n.hl    = q.mode[MRF_MODE_HDRLESS];
              n.txlen = wb_dat_i[7:0];
              n.dst   = q.mode[MRF_MODE_HDRLESS] ? q.hdst : wb_dat_i[15:8];
              n.bin   = wb_dat_i[MRF_SEND_BIN];
              n.uoff  = '0;
              n.uix   = '0;
              n.tries = '0;
              n.err   = 1'b0;
              n.fail  = 1'b0;
              n.done  = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end

    // sender
    case (q.s)
      S_DECODE:  lim = MRF_TW'(DECODE_CYC - 1);
      S_BUILD:   lim = MRF_TW'(BUILD_CYC - 1);
      S_CS:      lim = MRF_TW'(CS_CYC - 1);
      S_AIR:     lim = MRF_TW'(AIR_CYC - 1);
      S_AWAIT:   lim = MRF_TW'(ACKWAIT_CYC - 1);
      S_ACKPROC: lim = MRF_TW'(ACKPROC_CYC - 1);
      default:   lim = '0;
    endcase
    tdone = (q.st == lim);

    case (q.s)
      S_IDLE: ;
      S_DECODE: begin
        if (tdone) begin
          n.st = '0;
          if (q.hl ? (q.txlen > MRF_UNIT) : (q.txlen > MRF_MSG_MAX)) begin
            n.err  = 1'b1;
            n.wptr = '0;
            n.s    = S_IDLE;
          end else begin
            if (q.mode[MRF_MODE_RESP] && q.mode[MRF_MODE_ACCEPT]) begin
              n.rq    = 1'b1;
              n.rcode = 1'b1;
            end
            n.s = S_BUILD;
          end
        end
      end
      S_BUILD: begin
        if (tdone) begin
          n.st  = '0;
          n.seq = q.seq + 8'h01;
          n.s   = S_CS;
        end
      end
      S_CS: begin
        // any busy sample restarts the quiet interval; a jammed channel stalls here
        if (rf_busy) n.st = '0;
        else if (tdone) begin
          n.st   = '0;
          n.bidx = '0;
          n.s    = S_AIR;
        end
      end
      S_AIR: begin
        if (q.bidx < ulen || (ulen == 8'h00 && q.bidx == 8'h00)) begin
          n.tx.valid = 1'b1;
          n.tx.first = (q.bidx == 8'h00);
          n.tx.last  = (ulen == 8'h00) || (q.bidx == ulen - 8'h01);
          n.tx.dv    = (ulen != 8'h00);
          n.tx.fin   = lastu;
          n.tx.bin   = q.bin;
          n.tx.hl    = q.hl;
          n.tx.uix   = q.uix;
          n.tx.src   = q.own;
          n.tx.dst   = q.dst;
          n.tx.seq   = q.seq;
          n.tx.data  = q.txb[q.uoff + q.bidx];
          n.bidx     = q.bidx + 8'h01;
        end
        if (tdone) begin
          n.st = '0;
          if (q.dst == MRF_BCAST) begin
            if (q.tries == q.retry) nxt = 1'b1;
            else begin
              n.tries = q.tries + 4'h1;
              n.s     = S_CS;
            end
          end else begin
            n.s = S_AWAIT;
          end
        end
      end
      S_AWAIT: begin
        if (rf_ack_vld && rf_ack_src == q.dst) begin
          n.st = '0;
          n.s  = S_ACKPROC;
        end else if (tdone) begin
          n.st = '0;
          if (q.tries == q.retry) begin
            n.fail = 1'b1;
            n.wptr = '0;
            n.s    = S_IDLE;
          end else begin
            n.tries = q.tries + 4'h1;
            n.s     = S_CS;
          end
        end
      end
      S_ACKPROC: if (tdone) nxt = 1'b1;
      S_DONE: begin
        // completion waits until the accept response has left the port: both share rcode
        if (!q.rq && !(q.ob && !q.orx)) begin
          if (q.mode[MRF_MODE_RESP]) begin
            n.rq    = 1'b1;
            n.rcode = 1'b0;
          end
          n.done = 1'b1;
          n.wptr = '0;
          n.s    = S_IDLE;
        end
      end
      default: n.s = S_IDLE;
    endcase

    if (nxt) begin
      n.tries = '0;
      n.st    = '0;
      if (lastu) n.s = S_DONE;
      else begin
        n.uoff = q.uoff + ulen;
        n.uix  = q.uix + 3'h1;
        n.s    = S_CS;
      end
    end

    // receiver
    case (q.r)
      R_PROC:  rlim = MRF_TW'(RXPROC_CYC - 1);
      R_ACKG:  rlim = MRF_TW'(ACKGEN_CYC - 1);
      default: rlim = '0;
    endcase
    rdone = (q.rt == rlim);

    case (q.r)
      R_IDLE: begin
        // beats are dropped while processing or while this buffer is being printed
        if (rf_rx.valid && (rf_rx.first || q.inu) && !(q.ob && q.orx)) begin
          base = q.rxlen;
          if (rf_rx.first) begin
            acc    = !q.mode[MRF_MODE_ADRCHK] || rf_rx.dst == q.own
                     || rf_rx.dst == MRF_BCAST;
            kp     = acc && rf_rx.uix == q.unext
                     && !(q.lval && rf_rx.src == q.lsrc && rf_rx.seq == q.lseq);
            n.keep = kp;
            n.ackn = acc && q.mode[MRF_MODE_ADRCHK] && rf_rx.dst != MRF_BCAST;
            n.usrc = rf_rx.src;
            n.ufin = rf_rx.fin;
            n.inu  = 1'b1;
            if (kp && q.unext == 3'h0) begin
              n.rh = rf_rx;
              base = '0;
            end
          end
          n.rxlen = base;
          if (kp && rf_rx.dv && base < MRF_MSG_MAX) begin
            n.rxb[base] = rf_rx.data;
            n.rxlen     = base + 8'h01;
          end
          if (rf_rx.last) begin
            n.inu = 1'b0;
            if (kp || n.ackn) begin
              n.rt = '0;
              n.r  = R_PROC;
            end
          end
        end
      end
      R_PROC, R_ACKG: begin
        if (rdone) begin
          n.rt = '0;
          if (q.r == R_PROC && q.ackn) n.r = R_ACKG;
          else begin
            if (q.r == R_ACKG) begin
              n.aok  = 1'b1;
              n.adst = q.usrc;
            end
            n.r = R_IDLE;
            if (q.keep && q.ufin) begin
              n.r    = R_OUT;
              n.lval = 1'b1;
              n.lsrc = q.rh.src;
              n.lseq = q.rh.seq;
            end else if (q.keep) n.unext = q.unext + 3'h1;
          end
        end
      end
      R_OUT: begin
        if (!q.ob && !q.rq) begin
          n.ob    = 1'b1;
          n.orx   = 1'b1;
          n.opos  = '0;
          n.ohl   = q.mode[MRF_MODE_HDRLESS];
          n.olen  = (q.mode[MRF_MODE_HDRLESS] ? 8'h00 : (obin ? MRF_HDR_BIN : MRF_HDR_TXT))
                  + q.rxlen
                  + ((!q.mode[MRF_MODE_HDRLESS] || q.rxopt[MRF_RXOPT_CRLF])
                     ? MRF_CRLF_N : 8'h00);
          n.unext = '0;
          n.r     = R_IDLE;
        end
      end
      default: n.r = R_IDLE;
    endcase

    // serial output feeder: a pending response takes the free port only while the receiver is not in R_OUT
    if (!q.ob && q.rq && q.r != R_OUT) begin
      n.ob   = 1'b1;
      n.orx  = 1'b0;
      n.opos = '0;
      n.olen = MRF_RESP_N;
      n.rq   = 1'b0;
    end
    if (!q.orx) begin
      case (p[1:0])
        2'h0:    ch = MRF_CH_P;
        2'h1:    ch = q.rcode ? MRF_CH_1 : MRF_CH_0;
        2'h2:    ch = MRF_CH_CR;
        default: ch = MRF_CH_LF;
      endcase
    end else if (p < hlen) begin
      case (p)
        8'h00:   ch = MRF_CH_R;
        8'h01:   ch = obin ? MRF_CH_B : MRF_CH_X;
        8'h02:   ch = obin ? MRF_CH_N : MRF_CH_T;
        8'h03, 8'h04, 8'h05: ch = dec_digit(q.rh.src, 2'(p - 8'h03));
        default: ch = dec_digit(q.rxlen, 2'(p - 8'h06));
      endcase
    end else if (p - hlen < q.rxlen) begin
      ch = q.rxb[p - hlen];
    end else begin
      ch = (p - hlen == q.rxlen) ? MRF_CH_CR : MRF_CH_LF;
    end
    if (q.ob && u_ready) begin
      n.opos = q.opos + 8'h01;
      if (q.opos == q.olen - 8'h01) n.ob = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q          <= '0;
      q.s        <= S_IDLE;
      q.r        <= R_IDLE;
      q.line.div <= MRF_DIV_RST;
      q.retry    <= MRF_RETRY_RST;
    end else begin
      q <= n;
    end
  end

  mrf_uart_tx u_tx (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .line     (q.line),
    .in_valid (q.ob),
    .in_data  (ch),
    .in_ready (u_ready),
    .txd      (ser_txd)
  );

  assign wb_ack_o   = q.ack;
  assign wb_dat_o   = q.dat;
  assign rf_tx      = q.tx;
  assign rf_ack_req = q.aok;
  assign rf_ack_dst = q.adst;
endmodule

// ---- hdl/mrf_uart_tx.sv ----
// mrf_uart_tx: asynchronous serial character transmitter, lsb first.
// assumes the line settings are held stable while a character is in flight.
`timescale 1ns/1ps
module mrf_uart_tx
  import mrf_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      rst_b,
  input  mrf_pkg::mrf_line_t line,
  input  wire logic      in_valid,
  input  wire logic [7:0] in_data,
  output logic           in_ready,
  output logic           txd
);
  typedef struct packed {
    logic        busy;
    logic [11:0] sh;
    logic [3:0]  left;
    logic [15:0] div;
    logic        txd;
  } mrf_utx_t;

  mrf_utx_t q, n;
  logic [3:0] nd;

  always_comb begin
    n  = q;
    nd = line.d7 ? 4'h7 : 4'h8;
    if (!q.busy && in_valid) begin
      n.busy = 1'b1;
      n.sh   = '1;
      n.sh[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (4'(i) < nd) n.sh[i + 1] = in_data[i];
      end
      if (line.par_en) begin
        n.sh[nd + 4'h1] = line.par_odd ^ (^(in_data & (line.d7 ? 8'h7f : 8'hff)));
      end
      n.left = 4'h1 + nd + {3'h0, line.par_en} + (line.stop2 ? 4'h2 : 4'h1);
      n.div  = '0;
      n.txd  = 1'b0;
    end else if (q.busy) begin
      // bit-rate enable: one pulse every div cycles
      n.div = q.div + 16'h0001;
      if (q.div == line.div - 16'h0001) begin
        n.div  = '0;
        n.sh   = {1'b1, q.sh[11:1]};
        n.left = q.left - 4'h1;
        n.txd  = q.sh[1];
        if (q.left == 4'h1) begin
          n.busy = 1'b0;
          n.txd  = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q     <= '0;
      q.txd <= 1'b1;
      q.sh  <= '1;
    end else begin
      q <= n;
    end
  end

  assign in_ready = !q.busy;
  assign txd      = q.txd;
endmodule
